// file: design/aec_consts.svh
// Constants of the asynchronous event counter block.
`ifndef AEC_CONSTS_SVH
`define AEC_CONSTS_SVH
`define AEC_ADDR_EDGE 8'h00
`define AEC_ADDR_CLK 8'h04
`define AEC_ADDR_CSR 8'h08
`define AEC_ADDR_CNT_H 8'h0C
`define AEC_ADDR_CNT_L 8'h10
`define AEC_ADDR_IRQ 8'h14
`define AEC_RESP_OKAY 2'h0
`define AEC_RESP_SLVERR 2'h2
`define AEC_EDGE_FALL 2'h0
`define AEC_EDGE_RISE 2'h1
`define AEC_EDGE_BOTH 2'h2
`define AEC_SRC_PIN 2'h0
`define AEC_SRC_DIV2 2'h1
`define AEC_SRC_DIV4 2'h2
`define AEC_SRC_DIV8 2'h3
`define AEC_REG_RESET 8'h00
`define AEC_CNT_ZERO 8'h00
`define AEC_CNT_MAX 8'hFF
`define AEC_CNT_ONE 8'h01
`define AEC_DIV2_BITS 1
`define AEC_DIV4_BITS 2
`define AEC_DIV8_BITS 3
`define AEC_DIV64_BITS 6
`define AEC_OVH_BIT 7
`define AEC_OVL_BIT 6
`define AEC_IRQ_EC_FLAG_BIT 0
`define AEC_IRQ_GATE_FLAG_BIT 2
`endif

// file: design/aec_pkg.sv
// Register field types of the asynchronous event counter block.
`default_nettype none
package aec_pkg;
  typedef struct packed {
    logic [1:0] high_pin_edge_sel;
    logic [1:0] low_pin_edge_sel;
    logic [1:0] gate_pin_edge_sel;
    logic gating_pwm_enable;
    logic reserved0;
  } aec_edge_sel_t;
  typedef struct packed {
    logic [1:0] high_clock_sel;
    logic [1:0] low_clock_sel;
    logic [2:0] gating_pwm_clock_sel;
    logic reserved0;
  } aec_clk_ctrl_t;
  typedef struct packed {
    logic overflow_flag_high;
    logic overflow_flag_low;
    logic reserved5;
    logic channel_mode;
    logic count_enable_high;
    logic count_enable_low;
    logic reset_control_high;
    logic reset_control_low;
  } aec_csr_t;
  typedef struct packed {
    logic [3:0] unused;
    logic gate_irq_enable;
    logic gate_irq_flag;
    logic event_counter_irq_enable;
    logic event_counter_irq_flag;
  } aec_irq_t;
endpackage
`default_nettype wire

// file: design/aec_edge_det.sv
// Edge detector with selectable falling, rising or both edge sensing.
`include "aec_consts.svh"
`default_nettype none
module aec_edge_det (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and selection
  input wire logic pin,
  input wire logic [1:0] sel,
  // Detected edge
  output logic edge_pulse
);
  logic prev_reg;
  logic primed_reg;
  wire logic rise;
  wire logic fall;

  // No edge is reported on the first cycle after reset, as the old level is unknown.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= pin;
      primed_reg <= 1'b1;
    end
  end

  assign rise = primed_reg & pin & ~prev_reg;
  assign fall = primed_reg & ~pin & prev_reg;
  // The prohibited code senses nothing.
  assign edge_pulse = (sel == `AEC_EDGE_FALL) ? fall :
                      (sel == `AEC_EDGE_RISE) ? rise :
                      (sel == `AEC_EDGE_BOTH) ? (rise | fall) : 1'b0; // RQ1 RQ21

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_PROHIBITED_SILENT: assert property (sel == 2'h3 |-> !edge_pulse) // RQ21
    else $error("Edge reported under prohibited edge code.");
  AST_RISE_SEEN: assert property (
    (sel == `AEC_EDGE_RISE && $past(primed_reg) && $rose(pin)) |-> edge_pulse) // RQ1
    else $error("Rising edge missed.");
  AST_FALL_ONLY: assert property (
    (sel == `AEC_EDGE_FALL && edge_pulse) |-> ($past(pin) && !pin)) // RQ1
    else $error("Falling edge reported without a falling pin.");
endmodule
`default_nettype wire

// file: design/aec_top.sv
// Control, status and counting logic of the asynchronous event counter pair.
//
// Behaviour
// RQ1 - High event pin edge code: 00 falling, 01 rising, 10 both, 11 prohibited.
// RQ2 - Low event pin edge code: 00 falling, 01 rising, 10 both, 11 prohibited.
// RQ3 - Gate pin interrupt edge code: 00 falling, 01 rising, 10 both.
// RQ4 - PWM enable 0 halts PWM, gates by pin; 1 runs PWM, gates by PWM.
// RQ5 - Bit 0 of edge and clock registers is plain storage; software keeps 0.
// RQ6 - High clock select: pin, phi/2, phi/4 or phi/8.
// RQ7 - Low clock select: pin, phi/2, phi/4 or phi/8.
// RQ8 - PWM clock select codes 1X1 give phi/64.
// RQ9 - High overflow flag sets when high counter wraps FF to 00.
// RQ10 - Low overflow flag sets when low counter wraps FF to 00.
// RQ11 - High overflow flag clears only by writing 0 after reading 1.
// RQ12 - Low overflow flag clears only by writing 0 after reading 1.
// RQ13 - Status bit 5 is plain storage; software keeps it 0.
// RQ14 - Channel mode 0 joins counters into 16 bits; 1 gives two 8-bit.
// RQ15 - High count enable 0 blocks high counter clock and holds value.
// RQ16 - Low count enable 0 blocks low counter clock and holds value.
// RQ17 - Counter clocks pass only while the selected gate is high.
// RQ18 - In 16-bit mode the low overflow clocks the high counter.
// RQ19 - A 16-bit overflow sets the event counter interrupt flag.
// RQ20 - A counter is held at zero while its reset control bit is 0.
// RQ21 - Prohibited edge code senses no edges on that pin.
// RQ22 - Overflow events reach the status flags exactly once each.
`include "aec_consts.svh"
`default_nettype none
module aec_top #(
  parameter int PRE_W = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Event and gate pins
  input wire logic event_pin_high,
  input wire logic event_pin_low,
  input wire logic gate_interrupt_pin,
  input wire logic gating_pwm_output,
  // PWM generator control and interrupt
  output logic gating_pwm_run,
  output logic gating_pwm_clk_tick,
  output logic irq
);
  // The divide-by-64 tick needs at least six prescaler bits.
  if (PRE_W < `AEC_DIV64_BITS) begin : g_pre_w_check
    $error("PRE_W must be at least six.");
  end

  aec_pkg::aec_edge_sel_t edge_reg;
  aec_pkg::aec_clk_ctrl_t clk_reg;
  aec_pkg::aec_csr_t csr_reg;
  aec_pkg::aec_irq_t irq_reg;
  logic [7:0] hi_cnt_reg;
  logic [7:0] lo_cnt_reg;
  logic [PRE_W-1:0] presc_reg;
  logic arm_h_reg;
  logic arm_l_reg;
  logic pwm_tick_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Write channel: address and data are taken in either order.
  wire logic aw_hs = awvalid & awready;
  wire logic w_hs = wvalid & wready;
  wire logic wr_go = (aw_have_reg | aw_hs) & (w_have_reg | w_hs);
  wire logic [7:0] wr_addr = aw_have_reg ? awaddr_reg : awaddr;
  wire logic [7:0] wr_byte = w_have_reg ? wdata_reg : wdata[7:0];
  wire logic wr_lane = w_have_reg ? wstrb_reg : wstrb[0];
  wire logic wr_ok = (wr_addr == `AEC_ADDR_EDGE) | (wr_addr == `AEC_ADDR_CLK) |
                     (wr_addr == `AEC_ADDR_CSR) | (wr_addr == `AEC_ADDR_IRQ) |
                     (wr_addr == `AEC_ADDR_CNT_H) | (wr_addr == `AEC_ADDR_CNT_L);
  wire logic wr_en = wr_go & wr_lane;
  wire logic wr_edge = wr_en & (wr_addr == `AEC_ADDR_EDGE);
  wire logic wr_clk = wr_en & (wr_addr == `AEC_ADDR_CLK);
  wire logic wr_csr = wr_en & (wr_addr == `AEC_ADDR_CSR);
  wire logic wr_irq = wr_en & (wr_addr == `AEC_ADDR_IRQ);
  wire aec_pkg::aec_csr_t wcsr = wr_byte;
  wire aec_pkg::aec_irq_t wirq = wr_byte;

  // Read channel.
  wire logic ar_hs = arvalid & arready;
  wire logic rd_csr = ar_hs & (araddr == `AEC_ADDR_CSR);
  wire logic rd_ok = (araddr == `AEC_ADDR_EDGE) | (araddr == `AEC_ADDR_CLK) |
                     (araddr == `AEC_ADDR_CSR) | (araddr == `AEC_ADDR_IRQ) |
                     (araddr == `AEC_ADDR_CNT_H) | (araddr == `AEC_ADDR_CNT_L);
  wire logic [7:0] rd_byte = (araddr == `AEC_ADDR_EDGE) ? edge_reg :
                             (araddr == `AEC_ADDR_CLK) ? clk_reg :
                             (araddr == `AEC_ADDR_CSR) ? csr_reg :
                             (araddr == `AEC_ADDR_IRQ) ? irq_reg :
                             (araddr == `AEC_ADDR_CNT_H) ? hi_cnt_reg :
                             (araddr == `AEC_ADDR_CNT_L) ? lo_cnt_reg : `AEC_REG_RESET;

  assign awready = ~aw_have_reg & ~bvalid_reg;
  assign wready = ~w_have_reg & ~bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = ~rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= `AEC_REG_RESET;
      wdata_reg <= `AEC_REG_RESET;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `AEC_RESP_OKAY;
    end else begin
      aw_have_reg <= ~wr_go & (aw_have_reg | aw_hs);
      w_have_reg <= ~wr_go & (w_have_reg | w_hs);
      if (aw_hs) begin
        awaddr_reg <= awaddr;
      end
      if (w_hs) begin
        wdata_reg <= wdata[7:0];
        wstrb_reg <= wstrb[0];
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `AEC_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_ok ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Prescaler ticks; one cycle of aclk stands for one cycle of phi.
  wire logic tick2 = &presc_reg[`AEC_DIV2_BITS-1:0];
  wire logic tick4 = &presc_reg[`AEC_DIV4_BITS-1:0];
  wire logic tick8 = &presc_reg[`AEC_DIV8_BITS-1:0];
  wire logic tick64 = &presc_reg[`AEC_DIV64_BITS-1:0];
  wire logic pwm_div64 = clk_reg.gating_pwm_clock_sel[2] & clk_reg.gating_pwm_clock_sel[0]; // RQ8

  // Edge sensing on the three pins.
  logic ev_hi;
  logic ev_lo;
  logic ev_gate;
  aec_edge_det u_edge_hi (
    .aclk(aclk), .aresetn(aresetn), .pin(event_pin_high),
    .sel(edge_reg.high_pin_edge_sel), .edge_pulse(ev_hi) // RQ1
  );
  aec_edge_det u_edge_lo (
    .aclk(aclk), .aresetn(aresetn), .pin(event_pin_low),
    .sel(edge_reg.low_pin_edge_sel), .edge_pulse(ev_lo) // RQ2
  );
  aec_edge_det u_edge_gate (
    .aclk(aclk), .aresetn(aresetn), .pin(gate_interrupt_pin),
    .sel(edge_reg.gate_pin_edge_sel), .edge_pulse(ev_gate) // RQ3
  );

  // Source selection, gating and chaining.
  wire logic gate = edge_reg.gating_pwm_enable ? gating_pwm_output : gate_interrupt_pin; // RQ4
  wire logic lo_src = (clk_reg.low_clock_sel == `AEC_SRC_PIN) ? ev_lo :
                      (clk_reg.low_clock_sel == `AEC_SRC_DIV2) ? tick2 :
                      (clk_reg.low_clock_sel == `AEC_SRC_DIV4) ? tick4 : tick8; // RQ7
  wire logic hi_own = (clk_reg.high_clock_sel == `AEC_SRC_PIN) ? ev_hi :
                      (clk_reg.high_clock_sel == `AEC_SRC_DIV2) ? tick2 :
                      (clk_reg.high_clock_sel == `AEC_SRC_DIV4) ? tick4 : tick8; // RQ6
  wire logic lo_inc = lo_src & gate & csr_reg.count_enable_low & csr_reg.reset_control_low; // RQ16 RQ17
  wire logic lo_ovf = lo_inc & (lo_cnt_reg == `AEC_CNT_MAX);
  wire logic hi_src = csr_reg.channel_mode ? hi_own : lo_ovf; // RQ14 RQ18
  wire logic hi_inc = hi_src & gate & csr_reg.count_enable_high & csr_reg.reset_control_high; // RQ15 RQ17
  wire logic hi_ovf = hi_inc & (hi_cnt_reg == `AEC_CNT_MAX);
  wire logic ovf16 = hi_ovf & ~csr_reg.channel_mode;

  // Overflow flags: a new overflow wins over a clear in the same cycle.
  wire logic clr_h = wr_csr & ~wcsr.overflow_flag_high & arm_h_reg; // RQ11
  wire logic clr_l = wr_csr & ~wcsr.overflow_flag_low & arm_l_reg; // RQ12
  wire logic ovh_next = hi_ovf | (csr_reg.overflow_flag_high & ~clr_h); // RQ9 RQ22
  wire logic ovl_next = lo_ovf | (csr_reg.overflow_flag_low & ~clr_l); // RQ10 RQ22
  wire logic ecf_next = ovf16 | (irq_reg.event_counter_irq_flag &
                        ~(wr_irq & ~wirq.event_counter_irq_flag)); // RQ19
  wire logic gtf_next = ev_gate | (irq_reg.gate_irq_flag & ~(wr_irq & ~wirq.gate_irq_flag)); // RQ3

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_reg <= `AEC_REG_RESET;
      clk_reg <= `AEC_REG_RESET;
    end else begin
      if (wr_edge) begin
        edge_reg <= wr_byte; // RQ5
      end
      if (wr_clk) begin
        clk_reg <= wr_byte; // RQ5
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_reg <= `AEC_REG_RESET;
      irq_reg <= `AEC_REG_RESET;
      arm_h_reg <= 1'b0;
      arm_l_reg <= 1'b0;
    end else begin
      if (wr_csr) begin
        csr_reg[5:0] <= wr_byte[5:0]; // RQ13 RQ14 RQ20
      end
      csr_reg.overflow_flag_high <= ovh_next;
      csr_reg.overflow_flag_low <= ovl_next;
      if (wr_irq) begin
        irq_reg.event_counter_irq_enable <= wirq.event_counter_irq_enable;
        irq_reg.gate_irq_enable <= wirq.gate_irq_enable;
      end
      irq_reg.event_counter_irq_flag <= ecf_next;
      irq_reg.gate_irq_flag <= gtf_next;
      // A read of the status register arms the clear for each flag seen set.
      arm_h_reg <= rd_csr ? csr_reg.overflow_flag_high : (arm_h_reg & ~clr_h); // RQ11
      arm_l_reg <= rd_csr ? csr_reg.overflow_flag_low : (arm_l_reg & ~clr_l); // RQ12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !csr_reg.reset_control_low) begin
      lo_cnt_reg <= `AEC_CNT_ZERO; // RQ20
    end else if (lo_inc) begin
      lo_cnt_reg <= lo_cnt_reg + `AEC_CNT_ONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !csr_reg.reset_control_high) begin
      hi_cnt_reg <= `AEC_CNT_ZERO; // RQ20
    end else if (hi_inc) begin
      hi_cnt_reg <= hi_cnt_reg + `AEC_CNT_ONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= '0;
      pwm_tick_reg <= 1'b0;
    end else begin
      presc_reg <= presc_reg + PRE_W'(1);
      pwm_tick_reg <= tick64 & pwm_div64 & edge_reg.gating_pwm_enable; // RQ4 RQ8
    end
  end

  assign gating_pwm_run = edge_reg.gating_pwm_enable; // RQ4
  assign gating_pwm_clk_tick = pwm_tick_reg;
  assign irq = (irq_reg.event_counter_irq_flag & irq_reg.event_counter_irq_enable) |
               (irq_reg.gate_irq_flag & irq_reg.gate_irq_enable); // RQ19

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_low_wrap_16;
    lo_ovf && !csr_reg.channel_mode && gate && csr_reg.count_enable_high &&
      csr_reg.reset_control_high && !wr_csr;
  endsequence
  sequence s_high_stepped;
    hi_cnt_reg == 8'($past(hi_cnt_reg) + 8'h01);
  endsequence

  AST_CHAIN_16: assert property (s_low_wrap_16 |=> s_high_stepped) // RQ18
    else $error("Low wrap did not step the high counter in 16-bit mode.");
  AST_OVH_SET: assert property (hi_ovf |=> csr_reg.overflow_flag_high) // RQ9
    else $error("High overflow flag not set on wrap.");
  AST_OVL_SET: assert property (lo_ovf |=> csr_reg.overflow_flag_low ##1 1'b1) // RQ10
    else $error("Low overflow flag not set on wrap.");
  AST_OVH_KEEP_ON_ONE: assert property (
    (csr_reg.overflow_flag_high && wr_csr && wcsr.overflow_flag_high)
      |=> csr_reg.overflow_flag_high) // RQ11
    else $error("Writing one cleared the high overflow flag.");
  AST_OVL_NEEDS_READ: assert property (
    (csr_reg.overflow_flag_low && !arm_l_reg && !rd_csr) |=> csr_reg.overflow_flag_low) // RQ12
    else $error("Low overflow flag cleared without a prior read.");
  AST_HIGH_HOLD: assert property (
    (!csr_reg.count_enable_high && csr_reg.reset_control_high && !wr_csr)
      |=> $stable(hi_cnt_reg)) // RQ15
    else $error("High counter moved while its count enable was low.");
  AST_GATE_HOLD: assert property (
    (!gate && csr_reg.reset_control_low && !wr_csr) |=> $stable(lo_cnt_reg)) // RQ17
    else $error("Low counter moved while the gate was low.");
  AST_RESET_HOLD: assert property (!csr_reg.reset_control_high |=> hi_cnt_reg == 8'h00) // RQ20
    else $error("High counter not held at zero under reset control.");
  AST_IRQ_16: assert property (ovf16 |=> irq_reg.event_counter_irq_flag ##0
    (irq == irq_reg.event_counter_irq_enable || irq)) // RQ19
    else $error("Sixteen-bit overflow did not raise the interrupt flag.");
  AST_DIV2_RATE: assert property (
    (clk_reg.low_clock_sel == `AEC_SRC_DIV2 && tick2) |=> !tick2 ##1 tick2) // RQ7
    else $error("Half-rate tick not every second cycle.");
endmodule
`default_nettype wire

// file: tb/aec_event_src.sv
// Behavioural model of the event pins and gate sources facing the counter block.
`default_nettype none
module aec_event_src (
  // Clock
  input wire logic aclk,
  // Commands from the bench
  input wire logic tog_h,
  input wire logic tog_l,
  input wire logic gate_lvl,
  input wire logic pwm_lvl,
  // Pins toward the block
  output logic event_pin_high,
  output logic event_pin_low,
  output logic gate_interrupt_pin,
  output logic gating_pwm_output
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    event_pin_high = 1'b0;
    event_pin_low = 1'b0;
    gate_interrupt_pin = 1'b0;
    gating_pwm_output = 1'b0;
  end
  // Pins move just after an edge, so each toggle is one clean transition.
  always @(posedge aclk) begin
    if (tog_h) event_pin_high <= !event_pin_high;
    if (tog_l) event_pin_low <= !event_pin_low;
    gate_interrupt_pin <= gate_lvl;
    gating_pwm_output <= pwm_lvl;
  end
endmodule
`default_nettype wire

// file: tb/async_event_counter_control_tb_top.sv
// Self-checking bench of the event counter control block.
`default_nettype none
module async_event_counter_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd_v;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic tog_h, tog_l, gate_lvl, pwm_lvl;
  logic ev_h, ev_l, gate_pin, pwm_out, pwm_run, pwm_tick, irq;
  int n_fail, cmp_count, cyc, ticks, t_rd, c, ch, d, lv, c1, exp;
  aec_top aec_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .event_pin_high(ev_h), .event_pin_low(ev_l), .gate_interrupt_pin(gate_pin),
    .gating_pwm_output(pwm_out), .gating_pwm_run(pwm_run),
    .gating_pwm_clk_tick(pwm_tick), .irq(irq));
  aec_event_src aec_event_src_inst (.aclk(aclk), .tog_h(tog_h), .tog_l(tog_l),
    .gate_lvl(gate_lvl), .pwm_lvl(pwm_lvl), .event_pin_high(ev_h),
    .event_pin_low(ev_l), .gate_interrupt_pin(gate_pin), .gating_pwm_output(pwm_out));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pwm_tick === 1'b1) ticks <= ticks + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int t;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    bready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    wr_r = bresp;
    bready <= 1'b0;
    if (t == 50) begin
      n_fail++;
      $display("[FAIL] t=%0t write timeout addr=%h exp=%h", $time, a, 8'h01);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd_v = rdata;
    rd_r = rresp;
    t_rd = cyc;
    rready <= 1'b0;
    if (t == 50) begin
      n_fail++;
      $display("[FAIL] t=%0t read timeout addr=%h exp=%h", $time, a, 8'h01);
    end
  endtask
  task automatic tog(input int h, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (h != 0) tog_h <= 1'b1;
      else tog_l <= 1'b1;
      @(posedge aclk);
      tog_h <= 1'b0;
      tog_l <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge aclk);
    $display("[FAIL] t=%0t watchdog expired at cycle %h", $time, cyc);
    n_fail++;
    give_verdict;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {tog_h, tog_l, gate_lvl, pwm_lvl} = 4'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    {cyc, ticks, n_fail, cmp_count} = {32'h0, 32'h0, 32'h0, 32'h0};
    seed = 32'h71CA9225;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (c = 0; c <= 24; c += 4) begin
      rd(c[7:0]);
      chk(rd_v, 32'h0);
      chk(32'(rd_r), (c == 24) ? 32'h2 : 32'h0);
    end
    wr(8'h18, 32'h0);
    chk(32'(wr_r), 32'h2);
    for (c = 0; c < 8; c++) begin
      seed = xs(seed);
      wr({5'h0, c[0], 2'h0}, seed & 32'hFFFF_FFFE);
      rd({5'h0, c[0], 2'h0});
      chk(rd_v, {24'h0, seed[7:1], 1'b0});
    end
    $display("test registers done");
    wr(8'h04, 32'h0);
    gate_lvl <= 1'b1;
    for (ch = 0; ch < 2; ch++) for (c = 0; c < 4; c++) begin
      wr(8'h00, 32'(c << (4 + 2 * ch)));
      wr(8'h08, 32'h1C);
      wr(8'h08, 32'h1F);
      exp = 0;
      for (d = 0; d < 5; d++) begin
        lv = (ch != 0) ? 32'(ev_h) : 32'(ev_l);
        if (c == 2 || (c < 2 && c != lv)) exp++;
        tog(ch, 1);
      end
      rd((ch != 0) ? 8'h0C : 8'h10);
      chk(rd_v, 32'(exp));
    end
    $display("test edges done");
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h1C);
    wr(8'h08, 32'h1F);
    gate_lvl <= 1'b0;
    tog(0, 2);
    rd(8'h10);
    chk(rd_v, 32'h0);
    gate_lvl <= 1'b1;
    wr(8'h08, 32'h1B);
    tog(0, 2);
    rd(8'h10);
    chk(rd_v, 32'h0);
    wr(8'h08, 32'h17);
    tog(0, 2);
    tog(1, 2);
    rd(8'h10);
    chk(rd_v, 32'h2);
    rd(8'h0C);
    chk(rd_v, 32'h0);
    wr(8'h00, 32'h22);
    chk(32'(pwm_run), 32'h1);
    gate_lvl <= 1'b0;
    pwm_lvl <= 1'b1;
    wr(8'h08, 32'h1C);
    wr(8'h08, 32'h1F);
    tog(0, 2);
    rd(8'h10);
    chk(rd_v, 32'h2);
    pwm_lvl <= 1'b0;
    tog(0, 2);
    rd(8'h10);
    chk(rd_v, 32'h2);
    wr(8'h00, 32'h20);
    chk(32'(pwm_run), 32'h0);
    gate_lvl <= 1'b1;
    $display("test gating done");
    for (c = 1; c < 4; c++) begin
      wr(8'h04, 32'((c << 6) | (c << 4)));
      for (ch = 0; ch < 2; ch++) begin
        rd((ch != 0) ? 8'h0C : 8'h10);
        c1 = 32'(rd_v);
        d = t_rd;
        repeat (40) @(posedge aclk);
        rd((ch != 0) ? 8'h0C : 8'h10);
        lv = ((32'(rd_v) - c1) & 255) - ((t_rd - d) >> c);
        chk(32'(lv >= -1 && lv <= 1), 32'h1);
      end
    end
    $display("test prescaler done");
    wr(8'h04, 32'h50);
    wr(8'h08, 32'h1C);
    wr(8'h08, 32'h1F);
    repeat (600) @(posedge aclk);
    wr(8'h08, 32'h13);
    rd(8'h08);
    chk(rd_v, 32'hD3);
    wr(8'h08, 32'hD3);
    rd(8'h08);
    chk(rd_v, 32'hD3);
    wr(8'h08, 32'h13);
    rd(8'h08);
    chk(rd_v, 32'h13);
    wr(8'h04, 32'h30);
    wr(8'h08, 32'h0C);
    wr(8'h08, 32'h0F);
    repeat (2200) @(posedge aclk);
    wr(8'h08, 32'h03);
    rd(8'h0C);
    chk(rd_v, 32'h1);
    // A pin that toggles every cycle under both-edge sensing counts once per cycle.
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0C);
    wr(8'h08, 32'h0F);
    wr(8'h14, 32'h02);
    tog_l <= 1'b1;
    repeat (65536) @(posedge aclk);
    tog_l <= 1'b0;
    wr(8'h08, 32'h03);
    rd(8'h14);
    chk(rd_v, 32'h3);
    chk(32'(irq), 32'h1);
    rd(8'h10);
    chk(rd_v, 32'h0);
    rd(8'h0C);
    chk(rd_v, 32'h0);
    $display("test overflow done");
    wr(8'h00, 32'h02);
    for (c = 0; c < 8; c++) begin
      wr(8'h04, 32'(c << 1));
      repeat (2) @(posedge aclk);
      d = ticks;
      repeat (256) @(posedge aclk);
      lv = ticks - d;
      exp = (c == 5 || c == 7) ? 1 : 0;
      chk(32'((exp != 0) ? (lv >= 3 && lv <= 5) : (lv == 0)), 32'h1);
    end
    $display("test pwm clock done");
    for (c = 0; c < 4; c++) begin
      wr(8'h00, 32'(c << 2));
      gate_lvl <= 1'b0;
      repeat (4) @(posedge aclk);
      wr(8'h14, 32'h08);
      gate_lvl <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(8'h14);
      chk(rd_v, (c == 1 || c == 2) ? 32'hC : 32'h8);
      chk(32'(irq), 32'(c == 1 || c == 2));
      wr(8'h14, 32'h08);
      gate_lvl <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(8'h14);
      chk(rd_v, (c == 0 || c == 2) ? 32'hC : 32'h8);
    end
    $display("test gate interrupt done");
    give_verdict;
  end
endmodule
`default_nettype wire
